// ===== pkg/ispb_pkg.sv
// Behaviour
// - master_select high gives master, low slave; static
// - pin directions follow the role
// - driven MOSI or MISO is open-drain, low only
// - slave drives SCK and chip select push-pull
// - enable high keeps the device awake
// - master idles after chip select high 5.7ms
// - slave idles after line silent 5.7ms
// - wake within 8us on chip select fall or activity
// - line sample is +1, -1 or null
// - pulse timers classify short and long first
// - +1 is positive then negative half; -1 reversed
// - half-pulse 150ns long, 50ns short
// - long carries chip select, short carries data
// - master sends long on select edges, short per bit; with the queue full a newer bit replaces the pending one
// - slave long +1 raises, long -1 lowers select
// - slave short sets MOSI then pulses SCK
// - slave replies short -1 only when MISO low
// - slave never sends long or short +1
// - master: short -1 gives MISO 0, none gives 1
// - straps pick SCK idle level and latching edge
// - slave phase 1 moves SCK with chip select
// constants and types of the spi pulse bridge.
// assumes a 100 MHz system clock.
package ispb_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_W = 8;
	localparam int IDLE_W = 20;
	localparam int HALF_LONG_NS = 150;
	localparam int HALF_SHORT_NS = 50;
	localparam int RX_SHORT_MIN_NS = 30;
	localparam int RX_LONG_MIN_NS = 100;
	localparam int SLV_SETUP_FAST_NS = 145;
	localparam int SLV_SETUP_SLOW_NS = 1100;
	localparam int SLV_SCK_FAST_NS = 115;
	localparam int SLV_SCK_SLOW_NS = 1100;
	localparam int SLV_REPLY_FAST_NS = 145;
	localparam int SLV_REPLY_SLOW_NS = 1100;
	localparam int IDLE_TIME_US = 5700;
	localparam int IDLE_CYC_DEF = IDLE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int SYM_W = 2;
	localparam int SYM_LONG_BIT = 1;
	localparam int SYM_POS_BIT = 0;
	localparam int FIFO_DEPTH = 8;
	localparam logic CS_N_RST = 1'h1;
	localparam logic MISO_RST = 1'h1;

	function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
		return CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction : ns_to_cyc

	function automatic logic [SYM_W-1:0] sym_make(input logic long_sym, input logic pos_sym);
		return {long_sym, pos_sym};
	endfunction : sym_make

	localparam logic [CNT_W-1:0] HALF_LONG_CYC = ns_to_cyc(HALF_LONG_NS);
	localparam logic [CNT_W-1:0] HALF_SHORT_CYC = ns_to_cyc(HALF_SHORT_NS);
	localparam logic [CNT_W-1:0] RX_SHORT_MIN_CYC = ns_to_cyc(RX_SHORT_MIN_NS);
	localparam logic [CNT_W-1:0] RX_LONG_MIN_CYC = ns_to_cyc(RX_LONG_MIN_NS);

	typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_FIRST = 2'h1, TX_SECOND = 2'h2,
		TX_GAP = 2'h3} ispb_tx_st_t;
	typedef enum logic [1:0] {RX_WAIT = 2'h0, RX_FIRST = 2'h1, RX_SECOND = 2'h2} ispb_rx_st_t;
	typedef enum logic [1:0] {SL_IDLE = 2'h0, SL_SETUP = 2'h1, SL_PULSE = 2'h2,
		SL_REPLY = 2'h3} ispb_sl_st_t;
endpackage : ispb_pkg

// ===== verilog/ispb_bridge.sv
// spi to differential pulse bridge: symbol fifo and top level.
// assumes all pin inputs synchronous to sys_clk; straps stable.
`timescale 1ns/1ns

module ispb_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_nxt = push ? AW'((int'(wr_r) + 1) % DEPTH) : wr_r;
		rd_nxt = pop ? AW'((int'(rd_r) + 1) % DEPTH) : rd_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end
endmodule : ispb_fifo

module ispb_bridge #(
	parameter int IDLE_CYC = ispb_pkg::IDLE_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic master_select,
	input wire logic clock_polarity_strap,
	input wire logic clock_phase_strap,
	input wire logic slow_mode,
	input wire logic enable,
	input wire logic cs_n_in,
	output logic cs_n_out,
	output logic cs_n_oe,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic line_pos,
	input wire logic line_neg,
	output logic line_pos_drv,
	output logic line_neg_drv,
	output logic idle
);
	localparam int CW = ispb_pkg::CNT_W;

	function automatic logic [CW-1:0] pick_cyc(input logic slow, input int fast_ns,
		input int slow_ns);
		return slow ? ispb_pkg::ns_to_cyc(slow_ns) : ispb_pkg::ns_to_cyc(fast_ns);
	endfunction : pick_cyc

	// straps, caught while reset is held
	logic master_r, polarity_r, phase_r, slow_r;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			master_r <= master_select;
			polarity_r <= clock_polarity_strap;
			phase_r <= clock_phase_strap;
			slow_r <= slow_mode;
		end
	end

	// receiver level classification
	logic rx_is_pos, rx_is_neg;
	assign rx_is_pos = line_pos && !line_neg;
	assign rx_is_neg = line_neg && !line_pos;

	// receiver pulse timers
	ispb_pkg::ispb_rx_st_t rx_st_r, rx_st_nxt;
	logic [CW-1:0] rx_cnt_r, rx_cnt_nxt;
	logic rx_first_pos_r, rx_first_pos_nxt, rx_long_r, rx_long_nxt;
	logic rx_evt_r, rx_evt_nxt, rx_evt_long_r, rx_evt_long_nxt, rx_evt_pos_r, rx_evt_pos_nxt;
	logic rx_same, rx_opp;
	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_cnt_nxt = (rx_cnt_r == '1) ? rx_cnt_r : rx_cnt_r + CW'(1);
		rx_first_pos_nxt = rx_first_pos_r;
		rx_long_nxt = rx_long_r;
		rx_evt_nxt = 1'h0;
		rx_evt_long_nxt = rx_evt_long_r;
		rx_evt_pos_nxt = rx_evt_pos_r;
		rx_same = rx_first_pos_r ? rx_is_pos : rx_is_neg;
		rx_opp = rx_first_pos_r ? rx_is_neg : rx_is_pos;
		case (rx_st_r)
			ispb_pkg::RX_WAIT: begin
				rx_cnt_nxt = CW'(1);
				if (rx_is_pos || rx_is_neg) begin
					rx_first_pos_nxt = rx_is_pos;
					rx_st_nxt = ispb_pkg::RX_FIRST;
				end
			end
			ispb_pkg::RX_FIRST: begin
				if (rx_opp && rx_cnt_r >= ispb_pkg::RX_SHORT_MIN_CYC) begin
					rx_long_nxt = rx_cnt_r >= ispb_pkg::RX_LONG_MIN_CYC;
					rx_cnt_nxt = CW'(1);
					rx_st_nxt = ispb_pkg::RX_SECOND;
				end else if (!rx_same) begin
					rx_st_nxt = ispb_pkg::RX_WAIT;
				end
			end
			ispb_pkg::RX_SECOND: begin
				if (!rx_opp) begin
					rx_st_nxt = ispb_pkg::RX_WAIT;
					if (rx_cnt_r >= (rx_long_r ? ispb_pkg::RX_LONG_MIN_CYC :
						ispb_pkg::RX_SHORT_MIN_CYC)) begin
						rx_evt_nxt = 1'h1;
						rx_evt_long_nxt = rx_long_r;
						rx_evt_pos_nxt = rx_first_pos_r;
					end
				end
			end
			default: rx_st_nxt = ispb_pkg::RX_WAIT;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rx_st_r <= ispb_pkg::RX_WAIT;
			rx_cnt_r <= '0;
			rx_first_pos_r <= 1'h0;
			rx_long_r <= 1'h0;
			rx_evt_r <= 1'h0;
			rx_evt_long_r <= 1'h0;
			rx_evt_pos_r <= 1'h0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_first_pos_r <= rx_first_pos_nxt;
			rx_long_r <= rx_long_nxt;
			rx_evt_r <= rx_evt_nxt;
			rx_evt_long_r <= rx_evt_long_nxt;
			rx_evt_pos_r <= rx_evt_pos_nxt;
		end
	end

	// master front end, slave sequencer and symbol requests
	ispb_pkg::ispb_sl_st_t sl_st_r, sl_st_nxt;
	logic [CW-1:0] sl_cnt_r, sl_cnt_nxt;
	logic cs_prev_r, cs_prev_nxt, sck_prev_r, sck_prev_nxt;
	logic pend_cs_r, pend_cs_nxt, pend_cs_up_r, pend_cs_up_nxt;
	logic pend_dat_r, pend_dat_nxt, pend_dat_one_r, pend_dat_one_nxt;
	logic pend_rep_r, pend_rep_nxt, miso_val_r, miso_val_nxt;
	logic cs_q_r, cs_q_nxt, sck_q_r, sck_q_nxt, mosi_q_r, mosi_q_nxt;
	logic latch_edge, push_valid, push_ready, push_take;
	logic [ispb_pkg::SYM_W-1:0] push_sym;
	always_comb begin
		cs_prev_nxt = cs_n_in;
		sck_prev_nxt = sck_in;
		pend_cs_nxt = pend_cs_r;
		pend_cs_up_nxt = pend_cs_up_r;
		pend_dat_nxt = pend_dat_r;
		pend_dat_one_nxt = pend_dat_one_r;
		pend_rep_nxt = pend_rep_r;
		miso_val_nxt = miso_val_r;
		cs_q_nxt = cs_q_r;
		sck_q_nxt = sck_q_r;
		mosi_q_nxt = mosi_q_r;
		sl_st_nxt = sl_st_r;
		sl_cnt_nxt = sl_cnt_r + CW'(1);
		// latching edge is the rising one when polarity equals phase
		latch_edge = !cs_n_in && ((polarity_r == phase_r) ? (sck_in && !sck_prev_r) :
			(!sck_in && sck_prev_r));
		push_valid = pend_rep_r || pend_cs_r || pend_dat_r;
		if (pend_rep_r) begin
			push_sym = ispb_pkg::sym_make(1'h0, 1'h0);
		end else if (pend_cs_r) begin
			push_sym = ispb_pkg::sym_make(1'h1, pend_cs_up_r);
		end else begin
			push_sym = ispb_pkg::sym_make(1'h0, pend_dat_one_r);
		end
		push_take = push_valid && push_ready;
		if (push_take) begin
			if (pend_rep_r) begin
				pend_rep_nxt = 1'h0;
			end else if (pend_cs_r) begin
				pend_cs_nxt = 1'h0;
			end else begin
				pend_dat_nxt = 1'h0;
			end
		end
		if (master_r) begin
			if (cs_n_in != cs_prev_r) begin
				pend_cs_nxt = 1'h1;
				pend_cs_up_nxt = cs_n_in;
				miso_val_nxt = 1'h1;
			end
			if (latch_edge) begin
				pend_dat_nxt = 1'h1;
				pend_dat_one_nxt = mosi_in;
				miso_val_nxt = 1'h1;
			end
			if (rx_evt_r && !rx_evt_long_r && !rx_evt_pos_r) begin
				miso_val_nxt = 1'h0;
			end
		end else begin
			case (sl_st_r)
				ispb_pkg::SL_IDLE: begin
					sl_cnt_nxt = '0;
					if (rx_evt_r && rx_evt_long_r) begin
						cs_q_nxt = rx_evt_pos_r;
						if (phase_r) begin
							sck_q_nxt = rx_evt_pos_r ? polarity_r : !polarity_r;
						end
						if (!rx_evt_pos_r) begin
							sl_st_nxt = ispb_pkg::SL_REPLY;
						end
					end else if (rx_evt_r) begin
						mosi_q_nxt = rx_evt_pos_r;
						sl_st_nxt = ispb_pkg::SL_SETUP;
					end
				end
				ispb_pkg::SL_SETUP: begin
					if (sl_cnt_r >= pick_cyc(slow_r, ispb_pkg::SLV_SETUP_FAST_NS,
						ispb_pkg::SLV_SETUP_SLOW_NS) - CW'(1)) begin
						sck_q_nxt = !sck_q_r;
						sl_cnt_nxt = '0;
						sl_st_nxt = ispb_pkg::SL_PULSE;
					end
				end
				ispb_pkg::SL_PULSE: begin
					if (sl_cnt_r >= pick_cyc(slow_r, ispb_pkg::SLV_SCK_FAST_NS,
						ispb_pkg::SLV_SCK_SLOW_NS) - CW'(1)) begin
						sck_q_nxt = !sck_q_r;
						sl_cnt_nxt = '0;
						sl_st_nxt = ispb_pkg::SL_REPLY;
					end
				end
				ispb_pkg::SL_REPLY: begin
					if (sl_cnt_r >= pick_cyc(slow_r, ispb_pkg::SLV_REPLY_FAST_NS,
						ispb_pkg::SLV_REPLY_SLOW_NS) - CW'(1)) begin
						pend_rep_nxt = !miso_in;
						sl_st_nxt = ispb_pkg::SL_IDLE;
					end
				end
				default: sl_st_nxt = ispb_pkg::SL_IDLE;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cs_prev_r <= ispb_pkg::CS_N_RST;
			sck_prev_r <= clock_polarity_strap;
			pend_cs_r <= 1'h0;
			pend_cs_up_r <= 1'h0;
			pend_dat_r <= 1'h0;
			pend_dat_one_r <= 1'h0;
			pend_rep_r <= 1'h0;
			miso_val_r <= ispb_pkg::MISO_RST;
			cs_q_r <= ispb_pkg::CS_N_RST;
			sck_q_r <= clock_polarity_strap;
			mosi_q_r <= 1'h1;
			sl_st_r <= ispb_pkg::SL_IDLE;
			sl_cnt_r <= '0;
		end else begin
			cs_prev_r <= cs_prev_nxt;
			sck_prev_r <= sck_prev_nxt;
			pend_cs_r <= pend_cs_nxt;
			pend_cs_up_r <= pend_cs_up_nxt;
			pend_dat_r <= pend_dat_nxt;
			pend_dat_one_r <= pend_dat_one_nxt;
			pend_rep_r <= pend_rep_nxt;
			miso_val_r <= miso_val_nxt;
			cs_q_r <= cs_q_nxt;
			sck_q_r <= sck_q_nxt;
			mosi_q_r <= mosi_q_nxt;
			sl_st_r <= sl_st_nxt;
			sl_cnt_r <= sl_cnt_nxt;
		end
	end

	// pin drivers: open-drain data, push-pull slave clock and select
	logic cs_n_out_r, cs_n_oe_r, sck_out_r, sck_oe_r, mosi_oe_r, miso_oe_r;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cs_n_out_r <= ispb_pkg::CS_N_RST;
			cs_n_oe_r <= 1'h0;
			sck_out_r <= clock_polarity_strap;
			sck_oe_r <= 1'h0;
			mosi_oe_r <= 1'h0;
			miso_oe_r <= 1'h0;
		end else begin
			cs_n_out_r <= cs_q_nxt;
			cs_n_oe_r <= !master_r;
			sck_out_r <= sck_q_nxt;
			sck_oe_r <= !master_r;
			mosi_oe_r <= !master_r && !mosi_q_nxt;
			miso_oe_r <= master_r && !miso_val_nxt;
		end
	end
	assign cs_n_out = cs_n_out_r;
	assign cs_n_oe = cs_n_oe_r;
	assign sck_out = sck_out_r;
	assign sck_oe = sck_oe_r;
	assign mosi_out = 1'h0;
	assign mosi_oe = mosi_oe_r;
	assign miso_out = 1'h0;
	assign miso_oe = miso_oe_r;

	// idle timer
	logic [ispb_pkg::IDLE_W-1:0] idle_cnt_r, idle_cnt_nxt;
	logic idle_r, idle_nxt, activity;
	always_comb begin
		activity = master_r ? !cs_n_in : (rx_is_pos || rx_is_neg);
		idle_cnt_nxt = idle_cnt_r;
		idle_nxt = idle_r;
		if (enable || activity) begin
			idle_cnt_nxt = '0;
			idle_nxt = 1'h0;
		end else if (idle_cnt_r >= ispb_pkg::IDLE_W'(IDLE_CYC - 1)) begin
			idle_nxt = 1'h1;
		end else begin
			idle_cnt_nxt = idle_cnt_r + ispb_pkg::IDLE_W'(1);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			idle_cnt_r <= '0;
			idle_r <= 1'h0;
		end else begin
			idle_cnt_r <= idle_cnt_nxt;
			idle_r <= idle_nxt;
		end
	end
	assign idle = idle_r;

	// symbol queue and pulse transmitter
	logic fifo_valid, tx_pop;
	logic [ispb_pkg::SYM_W-1:0] fifo_sym;
	ispb_fifo #(.WIDTH(ispb_pkg::SYM_W), .DEPTH(ispb_pkg::FIFO_DEPTH)) u_fifo (
		.clk(sys_clk),
		.nrst(nrst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_sym),
		.out_valid(fifo_valid),
		.out_ready(tx_pop),
		.out_data(fifo_sym)
	);
	ispb_pkg::ispb_tx_st_t tx_st_r, tx_st_nxt;
	logic [CW-1:0] tx_cnt_r, tx_cnt_nxt, tx_half;
	logic tx_long_r, tx_long_nxt, tx_pos_r, tx_pos_nxt, pos_drv_r, neg_drv_r;
	assign tx_pop = (tx_st_r == ispb_pkg::TX_IDLE) && !idle_r;
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_cnt_nxt = tx_cnt_r + CW'(1);
		tx_long_nxt = tx_long_r;
		tx_pos_nxt = tx_pos_r;
		tx_half = tx_long_r ? ispb_pkg::HALF_LONG_CYC : ispb_pkg::HALF_SHORT_CYC;
		case (tx_st_r)
			ispb_pkg::TX_IDLE: begin
				tx_cnt_nxt = '0;
				if (fifo_valid && tx_pop) begin
					tx_long_nxt = fifo_sym[ispb_pkg::SYM_LONG_BIT];
					tx_pos_nxt = fifo_sym[ispb_pkg::SYM_POS_BIT];
					tx_st_nxt = ispb_pkg::TX_FIRST;
				end
			end
			ispb_pkg::TX_FIRST: begin
				if (tx_cnt_r == tx_half - CW'(1)) begin
					tx_cnt_nxt = '0;
					tx_st_nxt = ispb_pkg::TX_SECOND;
				end
			end
			ispb_pkg::TX_SECOND: begin
				if (tx_cnt_r == tx_half - CW'(1)) begin
					tx_cnt_nxt = '0;
					tx_st_nxt = ispb_pkg::TX_GAP;
				end
			end
			ispb_pkg::TX_GAP: begin
				// return to zero so back-to-back symbols stay apart
				if (tx_cnt_r == ispb_pkg::HALF_SHORT_CYC - CW'(1)) begin
					tx_st_nxt = ispb_pkg::TX_IDLE;
				end
			end
			default: tx_st_nxt = ispb_pkg::TX_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tx_st_r <= ispb_pkg::TX_IDLE;
			tx_cnt_r <= '0;
			tx_long_r <= 1'h0;
			tx_pos_r <= 1'h0;
			pos_drv_r <= 1'h0;
			neg_drv_r <= 1'h0;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_long_r <= tx_long_nxt;
			tx_pos_r <= tx_pos_nxt;
			pos_drv_r <= (tx_st_nxt == ispb_pkg::TX_FIRST && tx_pos_nxt) ||
				(tx_st_nxt == ispb_pkg::TX_SECOND && !tx_pos_nxt);
			neg_drv_r <= (tx_st_nxt == ispb_pkg::TX_FIRST && !tx_pos_nxt) ||
				(tx_st_nxt == ispb_pkg::TX_SECOND && tx_pos_nxt);
		end
	end
	assign line_pos_drv = pos_drv_r;
	assign line_neg_drv = neg_drv_r;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_short_plus;
		pos_drv_r[*5] ##1 neg_drv_r[*5] ##1 (!pos_drv_r && !neg_drv_r);
	endsequence
	sequence s_clk_setup;
		$stable(sck_out_r)[*3];
	endsequence

	chk_short_shape: assert property ((tx_st_r == ispb_pkg::TX_IDLE) && tx_pop && fifo_valid
		&& fifo_sym == 2'h1 |=> s_short_plus) else $error("short +1 shape wrong");
	chk_long_half: assert property ((tx_st_r == ispb_pkg::TX_FIRST) && tx_long_r
		&& (tx_st_nxt == ispb_pkg::TX_SECOND) |-> tx_cnt_r == 8'hE)
		else $error("long half not 150ns");
	chk_slave_sym: assert property (!master_r && push_take |-> push_sym == 2'h0)
		else $error("slave queued a forbidden symbol");
	chk_master_bit: assert property (master_r && latch_edge && !pend_cs_r && !pend_rep_r
		|=> pend_dat_r && pend_dat_one_r == $past(mosi_in))
		else $error("latched bit not queued");
	chk_slave_cs: assert property (!master_r && rx_evt_r && rx_evt_long_r
		|=> cs_n_out_r == $past(rx_evt_pos_r)) else $error("slave select wrong");
	chk_slave_mosi: assert property (!master_r && rx_evt_r && !rx_evt_long_r
		&& sl_st_r == ispb_pkg::SL_IDLE |=> (mosi_oe_r == !$past(rx_evt_pos_r)) ##0 s_clk_setup)
		else $error("mosi not set before clock");
	chk_enable_awake: assert property (enable |=> !idle_r)
		else $error("idle while enabled");
	chk_wake: assert property (master_r && idle_r && !cs_n_in |=> !idle_r ##1 !idle_r)
		else $error("no wake on select fall");
	chk_master_miso: assert property (master_r && rx_evt_r && !rx_evt_long_r && !rx_evt_pos_r
		|=> miso_oe_r) else $error("miso not pulled low");
	chk_role_dirs: assert property (master_r |-> !cs_n_oe_r && !sck_oe_r && !mosi_oe_r)
		else $error("master drives an input pin");
endmodule : ispb_bridge

// ===== tb/ispb_line_peer.sv
// line-side peer of the pulse bridge: sends symbols, decodes what the bridge drives.
// assumes comparator outputs read null (both low) whenever the peer is quiet.
`timescale 1ns/1ns

module ispb_line_peer (
	input wire logic sys_clk,
	input wire logic pos_drv,
	input wire logic neg_drv,
	output logic line_pos,
	output logic line_neg,
	output int rx_cnt,
	output int len_a,
	output int len_b,
	output logic rx_pos
);
	int run;
	logic [1:0] prv;
	logic [1:0] fst;

	initial begin
		line_pos = 1'h0;
		line_neg = 1'h0;
		prv = 2'h0;
		fst = 2'h0;
	end

	// a symbol ends when its second level returns to zero
	always @(posedge sys_clk) begin
		if ({pos_drv, neg_drv} != prv) begin
			if (prv != 2'h0 && fst == 2'h0) begin
				fst = prv;
				len_a = run;
			end else if (prv != 2'h0) begin
				len_b = run;
				rx_pos = fst[1];
				fst = 2'h0;
				rx_cnt++;
			end
			run = 0;
		end
		run++;
		prv = {pos_drv, neg_drv};
	end

	// first level carries the sign, then the opposite, then null
	task automatic send_sym(input int half, input logic pos, input int delay);
		repeat (delay + 1) @(negedge sys_clk);
		line_pos = pos;
		line_neg = !pos;
		repeat (half) @(negedge sys_clk);
		line_pos = !pos;
		line_neg = pos;
		repeat (half) @(negedge sys_clk);
		line_pos = 1'h0;
		line_neg = 1'h0;
	endtask : send_sym
endmodule : ispb_line_peer

// ===== tb/ispb_bridge_tb.sv
// testbench of the pulse bridge in both roles; the symbol queue is reached through the top.
// assumes the idle count is shortened to IDLE_N cycles for simulation.
`timescale 1ns/1ns

module ispb_bridge_tb;
	localparam int IDLE_N = 50;
	localparam int LONG_H = 150 / ispb_pkg::CLK_PERIOD_NS;
	localparam int SHORT_H = 50 / ispb_pkg::CLK_PERIOD_NS;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic polarity = 1'h0;
	logic phase = 1'h0;
	logic slow_mode = 1'h0; // fast slave timing, spi clock above the slow limit
	logic enable = 1'h1;
	logic cs_n_in = 1'h1;
	logic sck_in = 1'h0;
	logic mosi_in = 1'h1;
	logic miso_in = 1'h1;
	logic master_select = 1'h1;
	logic cs_n_out, cs_n_oe, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic line_pos, line_neg, pos_drv, neg_drv, idle, rx_pos;
	int rx_cnt, len_a, len_b, base, n;
	int error_cnt = 0;
	int tests_run = 0;

	always #5 sys_clk = ~sys_clk;

	ispb_bridge #(.IDLE_CYC(IDLE_N)) ispb_bridge_inst (.sys_clk(sys_clk), .nrst(nrst),
		.master_select(master_select), .clock_polarity_strap(polarity),
		.clock_phase_strap(phase), .slow_mode(slow_mode), .enable(enable),
		.cs_n_in(cs_n_in), .cs_n_out(cs_n_out), .cs_n_oe(cs_n_oe), .sck_in(sck_in),
		.sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
		.line_pos(line_pos), .line_neg(line_neg), .line_pos_drv(pos_drv),
		.line_neg_drv(neg_drv), .idle(idle));

	ispb_line_peer ispb_line_peer_inst (.sys_clk(sys_clk), .pos_drv(pos_drv),
		.neg_drv(neg_drv), .line_pos(line_pos), .line_neg(line_neg), .rx_cnt(rx_cnt),
		.len_a(len_a), .len_b(len_b), .rx_pos(rx_pos));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task automatic do_reset(input logic role);
		@(negedge sys_clk);
		nrst = 1'h0;
		master_select = role;
		// sck starts at the new idle level, else the first edge of a frame is lost
		sck_in = polarity;
		repeat (10) @(negedge sys_clk);
		chk("reset outputs", {1'h1, polarity, 7'h0}, {cs_n_out, sck_out, cs_n_oe, sck_oe,
			mosi_oe, miso_oe, pos_drv, neg_drv, idle});
		nrst = 1'h1;
		repeat (3) @(negedge sys_clk);
		chk("role drive", {role ? 3'h0 : 3'h6, 2'h0}, {cs_n_oe, sck_oe,
			role ? mosi_oe : miso_oe, mosi_out, miso_out});
	endtask : do_reset

	// waits for the next decoded symbol and compares its halves and sign
	task automatic expect_sym(input string what, input int half, input logic pos);
		for (n = 0; n < 90 && rx_cnt == base; n++) @(negedge sys_clk);
		chk(what, {8'h1, 8'(half), 8'(half), 7'h0, pos},
			{8'(rx_cnt - base), 8'(len_a), 8'(len_b), 7'h0, rx_pos});
		base++;
	endtask : expect_sym

	// mosi differs at the two edges, so only the latching edge yields b
	task automatic bit_out(input logic b);
		@(negedge sys_clk);
		mosi_in = b ^ phase;
		sck_in = !polarity;
		repeat (5) @(negedge sys_clk);
		mosi_in = b ^ !phase;
		sck_in = polarity;
		repeat (5) @(negedge sys_clk);
	endtask : bit_out

	task automatic master_frame();
		base = rx_cnt;
		cs_n_in = 1'h0;
		bit_out(1'h1);
		bit_out(1'h0);
		expect_sym("cs fall", LONG_H, 1'h0);
		expect_sym("bit one", SHORT_H, 1'h1);
		expect_sym("bit zero", SHORT_H, 1'h0);
		ispb_line_peer_inst.send_sym(SHORT_H, 1'h0, 2);
		repeat (4) @(negedge sys_clk);
		chk("miso after reply", 1, miso_oe);
		bit_out(1'h1);
		chk("miso no reply", 0, miso_oe);
		ispb_line_peer_inst.send_sym(1, 1'h0, 0);
		repeat (4) @(negedge sys_clk);
		chk("miso glitch", 0, miso_oe);
		expect_sym("bit last", SHORT_H, 1'h1);
		cs_n_in = 1'h1; // the last returned bit is of no interest here
		expect_sym("cs rise", LONG_H, 1'h1);
	endtask : master_frame

	task automatic master_idle();
		enable = 1'h0;
		for (n = 0; n < IDLE_N + 10 && idle !== 1'h1; n++) @(negedge sys_clk);
		chk("idle delay", 1, n >= IDLE_N - 2 && n <= IDLE_N + 2);
		base = rx_cnt;
		cs_n_in = 1'h0;
		repeat (3) @(negedge sys_clk);
		chk("wake", 0, idle);
		expect_sym("wake cs fall", LONG_H, 1'h0);
		enable = 1'h1;
		cs_n_in = 1'h1;
		for (n = 0; n < IDLE_N * 2 && idle !== 1'h1; n++) @(negedge sys_clk);
		chk("stay awake", 0, idle);
		expect_sym("idle cs rise", LONG_H, 1'h1);
	endtask : master_idle

	task automatic slave_test();
		polarity = 1'h0;
		phase = 1'h1;
		enable = 1'h0;
		do_reset(1'h0);
		repeat (IDLE_N + 5) @(negedge sys_clk);
		chk("slave idle", 1, idle);
		miso_in = 1'h0;
		base = rx_cnt;
		ispb_line_peer_inst.send_sym(LONG_H, 1'h0, 0);
		enable = 1'h1;
		repeat (3) @(negedge sys_clk);
		chk("slave select", 3'h1, {idle, cs_n_out, sck_out});
		expect_sym("select reply", SHORT_H, 1'h0);
		for (int b = 0; b < 2; b++) begin
			miso_in = b[0];
			ispb_line_peer_inst.send_sym(SHORT_H, b[0], 3);
			repeat (2) @(negedge sys_clk);
			chk("slave data", {!b[0], 1'h1}, {mosi_oe, sck_out});
			for (n = 0; n < 30 && sck_out !== 1'h0; n++) @(negedge sys_clk);
			chk("sck leave", 1, n < 30);
			for (n = 0; n < 30 && sck_out !== 1'h1; n++) @(negedge sys_clk);
			chk("sck return", 1, n < 30);
			if (b == 0) begin
				expect_sym("data reply", SHORT_H, 1'h0);
			end else begin
				repeat (60) @(negedge sys_clk);
				chk("no reply", base, rx_cnt);
			end
		end
		miso_in = 1'h0;
		ispb_line_peer_inst.send_sym(LONG_H, 1'h1, 0);
		repeat (3) @(negedge sys_clk);
		chk("slave deselect", 2'h2, {cs_n_out, sck_out});
		repeat (60) @(negedge sys_clk);
		chk("deselect silent", base, rx_cnt);
	endtask : slave_test

	// ten fast bits while the long symbol drains: eight fill the queue,
	// the ninth waits pending and the tenth overwrites it
	task automatic burst_test();
		logic [9:0] pat = 10'h1A5;
		base = rx_cnt;
		@(negedge sys_clk);
		cs_n_in = 1'h0;
		for (int k = 0; k < 10; k++) begin
			@(negedge sys_clk);
			mosi_in = pat[k] ^ phase;
			sck_in = !polarity;
			@(negedge sys_clk);
			mosi_in = pat[k] ^ !phase;
			sck_in = polarity;
		end
		expect_sym("burst cs fall", LONG_H, 1'h0);
		for (int k = 0; k < 9; k++) begin
			expect_sym("burst bit", SHORT_H, pat[(k < 8) ? k : 9]);
		end
		cs_n_in = 1'h1;
		expect_sym("burst cs rise", LONG_H, 1'h1);
	endtask : burst_test

	// slow slave timing stretches the setup before the clock pulse
	task automatic slow_test();
		slow_mode = 1'h1;
		do_reset(1'h0);
		miso_in = 1'h1;
		ispb_line_peer_inst.send_sym(LONG_H, 1'h0, 0);
		repeat (150) @(negedge sys_clk);
		ispb_line_peer_inst.send_sym(SHORT_H, 1'h1, 0);
		for (n = 0; n < 200 && sck_out !== 1'h0; n++) @(negedge sys_clk);
		chk("slow setup", 1, n > 100 && n < 130);
	endtask : slow_test

	initial begin
		for (int m = 0; m < 4; m++) begin
			polarity = m[1];
			phase = m[0];
			do_reset(1'h1);
			master_frame();
		end
		burst_test();
		master_idle();
		slave_test();
		slow_test();
		wrap_up();
	end

	initial begin
		repeat (10000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end
endmodule : ispb_bridge_tb
